/* File: core/dag_pkg.sv */
`default_nettype none
// ****************************************************************
// shared constants for address generation and repeat control
// ****************************************************************
package dag_pkg;
   localparam int DAG_AW        = 16;   // data address width
   localparam int DAG_DW        = 16;   // data word width
   localparam int DAG_OFS_W     = 7;    // in-page word offset bits
   localparam int DAG_PAGE_W    = 9;    // page pointer bits
   localparam int DAG_NPTR      = 8;    // pointer register count
   localparam int DAG_SEL_W     = 3;    // pointer select width
   localparam int DAG_RPT_W     = 8;    // repeat counter width

   localparam logic [DAG_PAGE_W-1:0] DAG_PAGE_RST = 9'h000;
   localparam logic [DAG_SEL_W-1:0]  DAG_SEL_RST  = 3'h0;
   localparam logic [DAG_RPT_W-1:0]  DAG_RPT_RST  = 8'h00;
   localparam logic [DAG_AW-1:0]     DAG_PTR_RST  = 16'h0000;
   localparam logic [DAG_AW-1:0]     DAG_ONE      = 16'h0001;
   localparam logic [DAG_SEL_W-1:0]  DAG_IDX_REG  = 3'h0;

   // ----- bus register map (byte addresses) -----
   localparam logic [7:0] DAG_A_CTRL   = 8'h00; // mode, update, strobes
   localparam logic [7:0] DAG_A_PAGE   = 8'h04; // page pointer
   localparam logic [7:0] DAG_A_SEL    = 8'h08; // pointer select
   localparam logic [7:0] DAG_A_OFS    = 8'h0c; // instruction offset
   localparam logic [7:0] DAG_A_IMM    = 8'h10; // immediate operand
   localparam logic [7:0] DAG_A_MEM    = 8'h14; // memory operand
   localparam logic [7:0] DAG_A_ADDR   = 8'h18; // address / operand out
   localparam logic [7:0] DAG_A_RPT    = 8'h1c; // repeat counter
   localparam logic [7:0] DAG_A_STAT   = 8'h20; // status
   localparam logic [7:0] DAG_A_PTR0   = 8'h40; // pointers 0x40..0x5c
   localparam int         DAG_PTR_SH   = 2;     // word index shift

   // ----- control register fields -----
   localparam int DAG_F_MODE    = 0;  // 2-bit addressing mode
   localparam int DAG_F_UPD     = 2;  // 3-bit pointer update
   localparam int DAG_F_EXEC    = 8;  // write 1: execute one step
   localparam int DAG_F_RPTM    = 9;  // write 1: repeat from memory
   localparam int DAG_F_REPEAT_IMMEDIATE_OP    = 10; // write 1: repeat immediate
   localparam int DAG_F_MULTI   = 11; // step is multicycle
   localparam int DAG_F_WAIT    = 12; // wait state stretches step
   localparam int DAG_F_IRQ     = 13; // write 1: interrupt request

   typedef enum logic [1:0] {
      DAG_MODE_DIRECT,
      DAG_MODE_INDIRECT,
      DAG_MODE_IMMED
   } dag_mode_t;

   typedef enum logic [2:0] {
      DAG_UPD_NONE,
      DAG_UPD_INC,
      DAG_UPD_DEC,
      DAG_UPD_ADD0,
      DAG_UPD_SUB0,
      DAG_UPD_BRINC,
      DAG_UPD_BRDEC
   } dag_upd_t;
endpackage
`default_nettype wire

/* File: core/dag_ptr_if.sv */
`default_nettype none
// ****************************************************************
// pointer-unit carrier between the core and its arithmetic unit
// ****************************************************************
interface dag_ptr_if;
   import dag_pkg::*;
   logic [DAG_AW-1:0] cur;   // selected pointer value
   logic [DAG_AW-1:0] idx;   // index pointer zero value
   dag_upd_t          upd;   // requested update
   logic [DAG_AW-1:0] nxt;   // updated pointer value
   modport core (output cur, output idx, output upd, input nxt);
   modport alu  (input cur, input idx, input upd, output nxt);
endinterface
`default_nettype wire

/* File: core/dag_ptr_alu.sv */
`default_nettype none
// ****************************************************************
// pointer arithmetic unit
// ****************************************************************
module dag_ptr_alu
   import dag_pkg::*;
(
   dag_ptr_if.alu p
);
   // bit-reverse helper: reversed carry is plain add on mirrored bits
   function automatic logic [DAG_AW-1:0] rev(input logic [DAG_AW-1:0] v);
      logic [DAG_AW-1:0] r;
      r = '0;
      for (int i = 0; i < DAG_AW; i++) begin
         r[i] = v[DAG_AW-1-i];
      end
      return r;
   endfunction

   // one update per step on the chosen pointer
   always_comb begin
      case (p.upd)
         DAG_UPD_INC:   p.nxt = p.cur + DAG_ONE;
         DAG_UPD_DEC:   p.nxt = p.cur - DAG_ONE;
         DAG_UPD_ADD0:  p.nxt = p.cur + p.idx;
         DAG_UPD_SUB0:  p.nxt = p.cur - p.idx;
         DAG_UPD_BRINC: p.nxt = rev(rev(p.cur) + rev(p.idx));
         DAG_UPD_BRDEC: p.nxt = rev(rev(p.cur) - rev(p.idx));
         default:       p.nxt = p.cur;
      endcase
   end
endmodule
`default_nettype wire

/* File: core/dag_core.sv */
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`default_nettype none
module dag_core
   import dag_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq_taken,
   output logic             dmem_rd
);
   // ****************************************************************
   // bus slave: address phase capture
   // ****************************************************************
   logic       wr_pend_q, wr_pend_d;  // write data phase pending
   logic [7:0] wr_addr_q, wr_addr_d;  // captured write address
   logic       rd_pend_q, rd_pend_d;  // read data phase pending
   logic [7:0] rd_addr_q, rd_addr_d;  // captured read address
   logic       take;                  // valid address phase

   // zero-wait slave; every access answers okay in the next cycle
   assign take      = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_comb begin
      wr_pend_d = take && hwrite;
      rd_pend_d = take && !hwrite;
      wr_addr_d = take ? haddr[7:0] : wr_addr_q;
      rd_addr_d = take ? haddr[7:0] : rd_addr_q;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rd_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= wr_pend_d;
         rd_pend_q <= rd_pend_d;
         wr_addr_q <= wr_addr_d;
         rd_addr_q <= rd_addr_d;
      end
   end

   // ****************************************************************
   // datapath state
   // ****************************************************************
   logic [DAG_PAGE_W-1:0] page_q, page_d;     // page pointer
   logic [DAG_SEL_W-1:0]  sel_q, sel_d;       // pointer_select
   logic [DAG_OFS_W-1:0]  ofs_q, ofs_d;       // instruction offset
   logic [DAG_DW-1:0]     imm_q, imm_d;       // instruction immediate
   logic [DAG_DW-1:0]     mem_q, mem_d;       // memory operand
   logic [1:0]            mode_q, mode_d;     // addressing mode
   logic [2:0]            upd_q, upd_d;       // pointer update kind
   logic                  multi_q, multi_d;   // multicycle step
   logic                  wait_q, wait_d;     // wait-state stretch
   logic [DAG_AW-1:0]     out_q, out_d;       // address or operand
   logic                  rd_q, rd_d;         // memory accessed
   logic [DAG_RPT_W-1:0]  rpt_q, rpt_d;       // repeat_count_reg
   logic                  rpt_on_q, rpt_on_d; // repeat armed/active
   logic                  busy_q, busy_d;     // wait-stretched step in flight
   logic                  irq_pend_q, irq_pend_d; // held interrupt
   logic                  irq_q, irq_d;       // interrupt taken pulse
   logic [DAG_DW-1:0]     pf_q, pf_d;         // prefetched word
   logic [DAG_AW-1:0]     ptr_q [DAG_NPTR];   // address_pointer_regs
   logic [DAG_AW-1:0]     ptr_d [DAG_NPTR];

   logic                  wr;                 // write data phase
   logic [31:0]           wd;                 // write data
   logic                  exec;               // step strobe
   logic                  ptr_hit;            // write hits pointer bank
   logic [DAG_SEL_W-1:0]  ptr_wi;             // written pointer index

   dag_ptr_if pif ();
   dag_ptr_alu u_alu (.p(pif));

   assign wr      = wr_pend_q;
   assign wd      = hwdata;
   assign exec    = wr && (wr_addr_q == DAG_A_CTRL) && wd[DAG_F_EXEC];
   assign ptr_hit = wr && (wr_addr_q[7:5] == DAG_A_PTR0[7:5]);
   assign ptr_wi  = wr_addr_q[DAG_PTR_SH +: DAG_SEL_W];

   // selected pointer feeds the arithmetic unit
   assign pif.cur = ptr_q[sel_q];
   assign pif.idx = ptr_q[DAG_IDX_REG];
   // a single step outside repeat uses the update kind written with it, not the stale one
   assign pif.upd = dag_upd_t'((exec && !rpt_on_q) ?
                               wd[DAG_F_UPD +: 3] : upd_q);

   // ****************************************************************
   // step, repeat and interrupt sequencing
   // ****************************************************************
   always_comb begin
      page_d     = page_q;
      sel_d      = sel_q;
      ofs_d      = ofs_q;
      imm_d      = imm_q;
      mem_d      = mem_q;
      mode_d     = mode_q;
      upd_d      = upd_q;
      multi_d    = multi_q;
      wait_d     = wait_q;
      out_d      = out_q;
      rd_d       = 1'b0;
      rpt_d      = rpt_q;
      rpt_on_d   = rpt_on_q;
      busy_d     = 1'b0;
      irq_pend_d = irq_pend_q;
      irq_d      = 1'b0;
      pf_d       = pf_q;
      for (int i = 0; i < DAG_NPTR; i++) begin
         ptr_d[i] = ptr_q[i];
      end
      // plain register writes
      if (wr) begin
         case (wr_addr_q)
            DAG_A_PAGE: page_d = wd[DAG_PAGE_W-1:0];
            DAG_A_OFS:  ofs_d  = wd[DAG_OFS_W-1:0];
            DAG_A_IMM:  imm_d  = wd[DAG_DW-1:0];
            DAG_A_MEM:  mem_d  = wd[DAG_DW-1:0];
            DAG_A_CTRL: begin
               mode_d  = wd[DAG_F_MODE +: 2];
               upd_d   = wd[DAG_F_UPD +: 3];
               multi_d = wd[DAG_F_MULTI];
               wait_d  = wd[DAG_F_WAIT];
            end
            default: ;
         endcase
         if (ptr_hit) begin
            ptr_d[ptr_wi] = wd[DAG_AW-1:0];
         end
      end
      // counter load: memory operand or immediate
      if (wr && (wr_addr_q == DAG_A_CTRL) && wd[DAG_F_RPTM]) begin
         rpt_d    = mem_q[DAG_RPT_W-1:0];
         rpt_on_d = 1'b1;
      end else if (wr && (wr_addr_q == DAG_A_CTRL) && wd[DAG_F_REPEAT_IMMEDIATE_OP]) begin
         rpt_d    = imm_q[DAG_RPT_W-1:0];
         rpt_on_d = 1'b1;
      end
      // a wait-stretched step stays busy one extra cycle
      if (exec && wd[DAG_F_WAIT] && !rpt_on_q) begin
         busy_d = 1'b1;
      end
      // execute one step: form address; only indirect mode updates the pointer
      if (exec || rpt_on_q) begin
         case (dag_mode_t'(rpt_on_q ? mode_q : wd[DAG_F_MODE +: 2]))
            DAG_MODE_DIRECT: begin
               out_d = {page_q, ofs_q};
               rd_d  = 1'b1;
            end
            DAG_MODE_INDIRECT: begin
               out_d = pif.cur;
               rd_d  = 1'b1;
               ptr_d[sel_q] = pif.nxt;
            end
            DAG_MODE_IMMED: begin
               out_d = imm_q;
            end
            default: ;
         endcase
         pf_d = imm_q;
      end
      // repeat: each iteration one cycle, count+1 in total
      if (rpt_on_q) begin
         if (rpt_q == DAG_RPT_RST) begin
            rpt_on_d = 1'b0;
         end else begin
            rpt_d = rpt_q - 8'h01;
         end
      end
      // pointer select changes only after the step's update
      if (wr && (wr_addr_q == DAG_A_SEL)) begin
         sel_d = wd[DAG_SEL_W-1:0];
      end
      // interrupt request held while repeat or stretch runs
      if (irq_pend_q && !rpt_on_q && !busy_q && !exec) begin
         irq_d      = 1'b1;
         irq_pend_d = 1'b0;
      end
      // a new request in the accepting cycle wins, so none is lost
      if (wr && (wr_addr_q == DAG_A_CTRL) && wd[DAG_F_IRQ]) begin
         irq_pend_d = 1'b1;
      end
   end

   // register everything; pointers reset to zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         page_q     <= DAG_PAGE_RST;
         sel_q      <= DAG_SEL_RST;
         ofs_q      <= '0;
         imm_q      <= '0;
         mem_q      <= '0;
         mode_q     <= '0;
         upd_q      <= '0;
         multi_q    <= 1'b0;
         wait_q     <= 1'b0;
         out_q      <= DAG_PTR_RST;
         rd_q       <= 1'b0;
         rpt_q      <= DAG_RPT_RST;
         rpt_on_q   <= 1'b0;
         busy_q     <= 1'b0;
         irq_pend_q <= 1'b0;
         irq_q      <= 1'b0;
         pf_q       <= '0;
         for (int i = 0; i < DAG_NPTR; i++) begin
            ptr_q[i] <= DAG_PTR_RST;
         end
      end else begin
         page_q     <= page_d;
         sel_q      <= sel_d;
         ofs_q      <= ofs_d;
         imm_q      <= imm_d;
         mem_q      <= mem_d;
         mode_q     <= mode_d;
         upd_q      <= upd_d;
         multi_q    <= multi_d;
         wait_q     <= wait_d;
         out_q      <= out_d;
         rd_q       <= rd_d;
         rpt_q      <= rpt_d;
         rpt_on_q   <= rpt_on_d;
         busy_q     <= busy_d;
         irq_pend_q <= irq_pend_d;
         irq_q      <= irq_d;
         pf_q       <= pf_d;
         for (int i = 0; i < DAG_NPTR; i++) begin
            ptr_q[i] <= ptr_d[i];
         end
      end
   end

   assign irq_taken = irq_q;
   assign dmem_rd   = rd_q;

   // ****************************************************************
   // read mux; unmapped addresses read zero
   // ****************************************************************
   always_comb begin
      hrdata = 32'h0000_0000;
      if (rd_pend_q) begin
         if (rd_addr_q[7:5] == DAG_A_PTR0[7:5]) begin
            hrdata[DAG_AW-1:0] = ptr_q[rd_addr_q[DAG_PTR_SH +: DAG_SEL_W]];
         end else begin
            case (rd_addr_q)
               DAG_A_CTRL: hrdata[13:0] = {1'b0, wait_q, multi_q, 3'b000,
                                           3'b000, upd_q, mode_q};
               DAG_A_PAGE: hrdata[DAG_PAGE_W-1:0] = page_q;
               DAG_A_SEL:  hrdata[DAG_SEL_W-1:0]  = sel_q;
               DAG_A_OFS:  hrdata[DAG_OFS_W-1:0]  = ofs_q;
               DAG_A_IMM:  hrdata[DAG_DW-1:0]     = imm_q;
               DAG_A_MEM:  hrdata[DAG_DW-1:0]     = mem_q;
               DAG_A_ADDR: hrdata[DAG_AW-1:0]     = out_q;
               DAG_A_RPT:  hrdata[DAG_RPT_W-1:0]  = rpt_q;
               // prefetched word sits in the upper half of status
               DAG_A_STAT: hrdata = {pf_q, 12'h000, irq_pend_q, busy_q,
                                     rpt_on_q, rd_q};
               default:    hrdata = 32'h0000_0000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* File: dv/dag_core_monitor.sv */
`default_nettype none
module dag_core_monitor
   import dag_pkg::*;
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        irq_taken,
   input wire logic        dmem_rd
);
   // ***************************
   // data-phase shadow
   // ***************************
   logic        dp_q, dp_d;  // data phase running
   logic        dw_q, dw_d;  // that phase writes
   logic [7:0]  da_q, da_d;  // its byte address
   logic [8:0]  pg_q, pg_d;  // page pointer copy
   logic [6:0]  of_q, of_d;  // offset copy
   logic [15:0] ex_q, ex_d;  // expected direct address
   logic        dv_q, dv_d;  // last control write was a direct step
   logic        rd_p;        // read data phase
   logic        wr_c;        // control write data phase
   assign rd_p = dp_q & ~dw_q;
   assign wr_c = dp_q & dw_q & (da_q == DAG_A_CTRL);
   // writes land at the end of their data phase, as in the slave
   always_comb begin
      dp_d = hsel & hready & htrans[1];
      dw_d = hwrite;
      da_d = haddr[7:0];
      pg_d = (dp_q & dw_q & da_q == DAG_A_PAGE) ? hwdata[8:0] : pg_q;
      of_d = (dp_q & dw_q & da_q == DAG_A_OFS) ? hwdata[6:0] : of_q;
      dv_d = wr_c ? (hwdata[DAG_F_EXEC] & hwdata[1:0] == 2'h0) : dv_q;
      ex_d = wr_c ? {pg_q, of_q} : ex_q;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {dp_q, dw_q, da_q, pg_q, of_q, ex_q, dv_q} <= '0;
      end else begin
         {dp_q, dw_q, da_q, pg_q, of_q, ex_q, dv_q} <=
            {dp_d, dw_d, da_d, pg_d, of_d, ex_d, dv_d};
      end
   end
   // ***************************
   // properties
   // ***************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_ready_high: assert property (hreadyout == 1'b1)
      else $error("slave inserted a wait state");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("slave answered with an error");
   a_page_back: assert property (rd_p && da_q == DAG_A_PAGE
      |-> hrdata == {23'h0, pg_q}) else $error("page readback wrong");
   a_ofs_back: assert property (rd_p && da_q == DAG_A_OFS
      |-> hrdata == {25'h0, of_q}) else $error("offset readback wrong");
   a_hole_zero: assert property (rd_p && da_q inside {[8'h24:8'h3c]}
      |-> hrdata == 32'h0) else $error("unmapped read not zero");
   a_direct_addr: assert property (rd_p && dv_q && da_q == DAG_A_ADDR
      |-> hrdata == {16'h0, ex_q}) else $error("direct address wrong");
   a_dmem_direct: assert property (wr_c && hwdata[DAG_F_EXEC]
      && hwdata[1:0] == 2'h0 |-> ##[1:2] dmem_rd)
      else $error("direct step did not reach memory");
   a_irq_pulse: assert property (irq_taken |=> !irq_taken)
      else $error("interrupt accepted twice");
   a_irq_held: assert property (wr_c && hwdata[DAG_F_EXEC]
      && hwdata[DAG_F_IRQ] |=> !irq_taken)
      else $error("interrupt taken during a step");
   // the stretch keeps the step busy for one more cycle
   a_irq_stretch: assert property (wr_c && hwdata[DAG_F_EXEC]
      && hwdata[DAG_F_WAIT] && hwdata[DAG_F_IRQ]
      |=> !irq_taken ##1 !irq_taken)
      else $error("interrupt taken during a stretched step");
   c_rpt: cover property (wr_c && hwdata[DAG_F_RPTM]);
   c_irq: cover property (irq_taken);
   c_dmem: cover property (dmem_rd);
endmodule
bind dag_core dag_core_monitor u_mon (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .irq_taken(irq_taken), .dmem_rd(dmem_rd)
);
`default_nettype wire

/* File: dv/tb.sv */
`default_nettype none
module tb
   import dag_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ***************************
   // signals and constants
   // ***************************
   localparam logic [31:0] EXEC  = 32'h1 << DAG_F_EXEC;  // one step
   localparam logic [31:0] MULTI = 32'h1 << DAG_F_MULTI; // multicycle
   localparam logic [31:0] IRQ   = 32'h1 << DAG_F_IRQ;   // interrupt
   localparam logic [31:0] STRW  = 32'h1 << DAG_F_WAIT;  // wait state
   localparam logic [31:0] INC   = 32'h5;                // indirect, +1
   logic        hclk        = 1'b0;  // core clock
   logic        hresetn     = 1'b0;  // reset, active low
   logic        hsel        = 1'b1;  // lone slave stays selected
   logic [31:0] haddr       = 32'h0; // address phase
   logic [1:0]  htrans      = 2'h0;  // idle at start
   logic        hwrite      = 1'b0;  // direction
   logic [2:0]  hsize       = 3'h2;  // whole words only
   logic [31:0] hwdata      = 32'h0; // write data
   logic        hready;              // bus ready
   logic [31:0] hrdata;              // read data
   logic        hreadyout;           // slave ready
   logic        hresp;               // slave response
   logic        irq_taken;           // interrupt accepted
   logic        dmem_rd;             // step read data memory
   int          err_total   = 0;     // mismatches
   int          comparisons = 0;     // checks made
   int          cyc         = 0;     // cycle count
   int          irq_cnt     = 0;     // accepted interrupts
   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   // count cycles and accepted interrupts
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (irq_taken === 1'b1) begin
         irq_cnt <= irq_cnt + 1;
      end
   end
   dag_core u_dag_core (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .irq_taken(irq_taken), .dmem_rd(dmem_rd)
   );
   // ***************************
   // bus tasks
   // ***************************
   task automatic finish_test;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // bounded wait for ready; a stuck slave ends the run
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      if (hready !== 1'b1) begin
         check(32'h0, 32'h1, "ready timeout");
         finish_test();
      end
   endtask
   // one single transfer, entered just after a clock edge
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'b10;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                         input string what);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      check(q, e, what);
   endtask
   function automatic logic [15:0] rev(input logic [15:0] v);
      for (int i = 0; i < 16; i++) rev[i] = v[15-i];
   endfunction
   // repeat of an incrementing step; pointer 2 counts the executions
   task automatic run_rpt(input logic [31:0] go, input int n,
                          input logic irq);
      int          t0;
      logic [31:0] q;
      wr(DAG_A_PTR0 + 8'h8, 32'h0);
      wr(DAG_A_SEL, 32'h2);
      t0 = cyc;
      wr(DAG_A_CTRL, go | MULTI | INC);
      if (irq) wr(DAG_A_CTRL, MULTI | INC | IRQ);
      for (int k = 0; k < 400; k++) begin
         xfer(1'b0, DAG_A_STAT, 32'h0, q);
         if (q[1] !== 1'b1) break;
         if (irq) check(32'(irq_cnt), 32'h0, "irq held");
      end
      check(32'(cyc - t0 inside {[n:n + 12]}), 32'h1, "pace");
      rd_chk(DAG_A_PTR0 + 8'h8, 32'(n), "repeat runs");
   endtask
   // ***************************
   // main sequence
   // ***************************
   initial begin
      logic [15:0] p;
      logic [15:0] e;
      logic [8:0]  pg;
      logic [6:0]  of;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 24; i++) rd_chk(8'(i * 4), 32'h0, "reset");
      wr(DAG_A_RPT, 32'h55);
      wr(8'h3c, 32'h77);
      rd_chk(DAG_A_RPT, 32'h0, "read-only");
      rd_chk(8'h3c, 32'h0, "hole");
      for (int k = 0; k < 2; k++) begin
         pg = k ? 9'h1ff : 9'h0a5;
         of = k ? 7'h7f : 7'h2c;
         wr(DAG_A_PAGE, {23'h0, pg});
         wr(DAG_A_OFS, {25'h0, of});
         wr(DAG_A_CTRL, EXEC);
         rd_chk(DAG_A_ADDR, {16'h0, pg, of}, "direct");
         rd_chk(DAG_A_PAGE, {23'h0, pg}, "page");
      end
      wr(DAG_A_PTR0, 32'h8);
      for (int u = 0; u < 7; u++) begin
         p = 16'h8230 + 16'(u);
         wr(DAG_A_PTR0 + 8'((u + 1) * 4), {16'h0, p});
         wr(DAG_A_SEL, 32'(u + 1));
         wr(DAG_A_CTRL, EXEC | (32'(u) << DAG_F_UPD) | 32'h1);
         wr(DAG_A_SEL, 32'h0);
         rd_chk(DAG_A_ADDR, {16'h0, p}, "indirect");
         case (u)
            1: e = p + 16'h1;
            2: e = p - 16'h1;
            3: e = p + 16'h8;
            4: e = p - 16'h8;
            5: e = rev(rev(p) + rev(16'h8));
            6: e = rev(rev(p) - rev(16'h8));
            default: e = p;
         endcase
         rd_chk(DAG_A_PTR0 + 8'((u + 1) * 4), {16'h0, e}, "update");
      end
      rd_chk(DAG_A_PTR0, 32'h8, "index kept");
      wr(DAG_A_IMM, 32'hbeef);
      wr(DAG_A_CTRL, EXEC | 32'h2);
      rd_chk(DAG_A_ADDR, 32'hbeef, "immediate");
      // the step latched its instruction word as the prefetch
      rd_chk(DAG_A_STAT, 32'hbeef_0000, "prefetch");
      wr(DAG_A_MEM, 32'hff);
      run_rpt(32'h1 << DAG_F_RPTM, 256, 1'b1);
      for (int k = 0; k < 10 && irq_cnt < 1; k++) @(posedge hclk);
      check(32'(irq_cnt), 32'h1, "irq after repeat");
      wr(DAG_A_IMM, 32'h3);
      run_rpt(32'h1 << DAG_F_REPEAT_IMMEDIATE_OP, 4, 1'b0);
      wr(DAG_A_CTRL, EXEC | STRW | IRQ | 32'h2);
      for (int k = 0; k < 10 && irq_cnt < 2; k++) @(posedge hclk);
      check(32'(irq_cnt), 32'h2, "irq after step");
      finish_test();
   end
   // watchdog for the whole run
   initial begin
      repeat (60000) @(posedge hclk);
      check(32'h0, 32'h1, "run timeout");
      finish_test();
   end
endmodule
`default_nettype wire
